// ### hdl/sfe_params.svh
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

// Core clock rate, in MHz
`define SFE_CLK_MHZ 25
// Self-timed durations, in microseconds
`define SFE_PAGE_ERASE_TIME_US 10000
`define SFE_BLOCK_CLEAR_TIME_US 1000000
`define SFE_SLEEP_ENTRY_DELAY_US 3
`define SFE_WAKE_DELAY_US 3
// Shortest write lockout after power-up, in microseconds
`define SFE_WRITE_LOCKOUT_TIME_US 1000
// Derived cycle counts, at least one cycle each
`define SFE_PAGE_ERASE_CYC (`SFE_PAGE_ERASE_TIME_US * `SFE_CLK_MHZ)
`define SFE_BLOCK_CLEAR_CYC (`SFE_BLOCK_CLEAR_TIME_US * `SFE_CLK_MHZ)
`define SFE_SLEEP_ENTRY_CYC (`SFE_SLEEP_ENTRY_DELAY_US * `SFE_CLK_MHZ)
`define SFE_WAKE_CYC (`SFE_WAKE_DELAY_US * `SFE_CLK_MHZ)
`define SFE_WRITE_LOCKOUT_CYC (`SFE_WRITE_LOCKOUT_TIME_US * `SFE_CLK_MHZ)

// Frame lengths in serial clock bits
`define SFE_OPCODE_BITS 6'h08
`define SFE_ADDR_FRAME_BITS 6'h20
// Address layout: A23..A20 ignored, page and sector fields
`define SFE_ADDR_MSB 19
`define SFE_PAGE_LSB 8
`define SFE_SECTOR_LSB 16
// Sector guarded by the hardware write protect pin
`define SFE_PROTECTED_SECTOR 4'h0

`endif

// ### hdl/sfe_pkg.sv
package sfe_pkg;

	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_ERASE = 3'b001,
		ST_SLEEP_ENTRY = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE = 3'b100
	} sfe_state_t;

	typedef struct packed {
		logic block;
		logic [19:0] base;
	} sfe_erase_req_t;

endpackage : sfe_pkg

// ### hdl/sfe_erase_power_seq.sv
// Contract
// - Page erase sets addressed page to FFh
// - Block erase sets addressed sector to FFh
// - Erase accepted only with unlock latch set
// - Page erase: opcode, three address bytes
// - Any address in sector selects sector
// - Top four address bits are ignored
// - Erase runs only on deselect after bit 32
// - Cycle starts at deselect; busy; latch clears
// - Page erase on protected page refused
// - Block erase over protected page refused
// - Commands rejected while any cycle runs
// - Deselect gives standby only when idle
// - Sleep entry: deselect after bit 8, delay
// - Deep sleep ignores write and erase commands
// - Power loss ends sleep; come up standby
// - Wake rejected on extra serial clocks
// - Standby after wake delay; select stays high
// - Reset holds logic, no instruction answered
// - Write commands ignored during power-up lockout
// - Power-up: standby, latch and busy clear
`timescale 1ns/1ps
`include "sfe_params.svh"

module sfe_erase_power_seq #(
	parameter logic [7:0] WRITE_UNLOCK_OP = 8'h01,
	parameter logic [7:0] PAGE_ERASE_OP = 8'h02,
	parameter logic [7:0] BLOCK_CLEAR_OP = 8'h03,
	parameter logic [7:0] DEEP_SLEEP_OP = 8'h04,
	parameter logic [7:0] WAKE_OP = 8'h05,
	parameter int TMR_W = 32,
	parameter logic [31:0] PAGE_ERASE_CYC = 32'(`SFE_PAGE_ERASE_CYC),
	parameter logic [31:0] BLOCK_CLEAR_CYC = 32'(`SFE_BLOCK_CLEAR_CYC),
	parameter logic [31:0] WRITE_LOCKOUT_CYC = 32'(`SFE_WRITE_LOCKOUT_CYC)
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	input wire logic wp_n_in,
	input wire logic ext_cycle_busy_in,
	output logic busy_flag_out,
	output logic write_unlock_latch_out,
	output logic standby_out,
	output logic deep_sleep_out,
	output logic lockout_out,
	output logic erase_start_out,
	output sfe_pkg::sfe_erase_req_t erase_req_out
);

	localparam logic [TMR_W-1:0] SLEEP_ENTRY_CYC = TMR_W'(`SFE_SLEEP_ENTRY_CYC);
	localparam logic [TMR_W-1:0] WAKE_CYC = TMR_W'(`SFE_WAKE_CYC);
	localparam logic [TMR_W-1:0] TMR_ONE = TMR_W'(1);

	sfe_pkg::sfe_state_t state;
	logic [5:0] bit_cnt;
	logic [31:0] shift;
	logic [TMR_W-1:0] tmr;
	logic [31:0] lock_cnt;
	logic unlock_latch;
	logic locked;

	logic sclk_rise;
	logic cs_rise;
	logic [7:0] frame_op;
	logic [7:0] short_op;
	logic [`SFE_ADDR_MSB:0] frame_addr;
	logic cycle_running;
	logic op_frame;
	logic addr_frame;
	logic page_hit_prot;
	logic block_hit_prot;
	logic may_modify;
	logic go_page;
	logic go_block;
	logic go_unlock;
	logic go_sleep;
	logic go_wake;
	logic tmr_done;

	// Opcode sits in the top byte after a full address frame
	assign frame_op = shift[31:24];
	assign short_op = shift[7:0];
	// A23..A20 dropped by taking the low 20 bits only
	assign frame_addr = shift[`SFE_ADDR_MSB:0];
	assign cycle_running = (state == sfe_pkg::ST_ERASE) | ext_cycle_busy_in;
	// Exact bit count at deselect, anything else is discarded
	assign op_frame = cs_rise & (bit_cnt == `SFE_OPCODE_BITS);
	assign addr_frame = cs_rise & (bit_cnt == `SFE_ADDR_FRAME_BITS);
	// Bottom sector guarded while the protect pin is low
	assign block_hit_prot = ~wp_n_in &
		(frame_addr[`SFE_ADDR_MSB:`SFE_SECTOR_LSB] == `SFE_PROTECTED_SECTOR);
	assign page_hit_prot = block_hit_prot;
	// No modifying command while busy, asleep or locked out
	assign may_modify = (state == sfe_pkg::ST_STANDBY) & ~cycle_running & ~locked;
	assign go_unlock = op_frame & (short_op == WRITE_UNLOCK_OP) & may_modify;
	assign go_page = addr_frame & (frame_op == PAGE_ERASE_OP) & may_modify &
		unlock_latch & ~page_hit_prot;
	assign go_block = addr_frame & (frame_op == BLOCK_CLEAR_OP) & may_modify &
		unlock_latch & ~block_hit_prot;
	assign go_sleep = op_frame & (short_op == DEEP_SLEEP_OP) &
		(state == sfe_pkg::ST_STANDBY) & ~cycle_running;
	// Only the wake opcode is heard in deep sleep
	assign go_wake = op_frame & (short_op == WAKE_OP) & (state == sfe_pkg::ST_SLEEP) &
		~ext_cycle_busy_in;
	assign tmr_done = (tmr == TMR_ONE);

	// Edge finders reset to each pin's idle level, so reset release is no edge
	sfe_rise_det #(
		.IDLE(1'b0)
	) sclk_edge (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.pin_in(sclk_in),
		.rise_out(sclk_rise)
	);

	sfe_rise_det #(
		.IDLE(1'b1)
	) cs_edge (
		.core_clk_in(core_clk_in),
		.nrst_in(nrst_in),
		.pin_in(cs_n_in),
		.rise_out(cs_rise)
	);

	// Serial shifter; counter saturates so long frames never alias to 32
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			bit_cnt <= 6'h00;
			shift <= 32'h0000_0000;
		end else if (cs_n_in) begin
			bit_cnt <= 6'h00;
		end else if (sclk_rise) begin
			shift <= {shift[30:0], sdi_in};
			if (bit_cnt != 6'h3F) begin
				bit_cnt <= bit_cnt + 6'h01;
			end
		end
	end

	// Power-up write lockout, restarted by every reset
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			lock_cnt <= 32'h0000_0000;
			locked <= 1'b1;
		end else if (locked) begin
			if (lock_cnt >= WRITE_LOCKOUT_CYC - 32'h0000_0001) begin
				locked <= 1'b0;
			end
			lock_cnt <= lock_cnt + 32'h0000_0001;
		end
	end

	// Unlock latch: cleared as the erase cycle starts, well before its end
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			unlock_latch <= 1'b0;
		end else if (go_page | go_block) begin
			unlock_latch <= 1'b0;
		end else if (go_unlock) begin
			unlock_latch <= 1'b1;
		end
	end

	// Mode sequencer; reset always lands in standby, never in sleep
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			state <= sfe_pkg::ST_STANDBY;
		end else begin
			case (state)
				sfe_pkg::ST_STANDBY: begin
					if (go_page | go_block) begin
						state <= sfe_pkg::ST_ERASE;
					end else if (go_sleep) begin
						state <= sfe_pkg::ST_SLEEP_ENTRY;
					end
				end
				sfe_pkg::ST_ERASE: begin
					// New frames are ignored; the timer runs on untouched
					if (tmr_done) begin
						state <= sfe_pkg::ST_STANDBY;
					end
				end
				sfe_pkg::ST_SLEEP_ENTRY: begin
					if (tmr_done) begin
						state <= sfe_pkg::ST_SLEEP;
					end
				end
				sfe_pkg::ST_SLEEP: begin
					// Only wake is heard here; the entry and wake delays hear nothing
					if (go_wake) begin
						state <= sfe_pkg::ST_WAKE;
					end
				end
				sfe_pkg::ST_WAKE: begin
					// Host keeps select high until the wake delay is over
					if (tmr_done) begin
						state <= sfe_pkg::ST_STANDBY;
					end
				end
				default: begin
					state <= sfe_pkg::ST_STANDBY;
				end
			endcase
		end
	end

	// Self-timed delays share one down-counter; a cycle ends when it reads one
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			tmr <= TMR_W'(0);
		end else begin
			case (state)
				sfe_pkg::ST_STANDBY: begin
					if (go_page) begin
						tmr <= TMR_W'(PAGE_ERASE_CYC);
					end else if (go_block) begin
						tmr <= TMR_W'(BLOCK_CLEAR_CYC);
					end else if (go_sleep) begin
						tmr <= SLEEP_ENTRY_CYC;
					end
				end
				sfe_pkg::ST_SLEEP: begin
					if (go_wake) begin
						tmr <= WAKE_CYC;
					end
				end
				sfe_pkg::ST_ERASE: begin
					tmr <= tmr - TMR_ONE;
				end
				sfe_pkg::ST_SLEEP_ENTRY: begin
					tmr <= tmr - TMR_ONE;
				end
				sfe_pkg::ST_WAKE: begin
					tmr <= tmr - TMR_ONE;
				end
				default: begin
					tmr <= TMR_W'(0);
				end
			endcase
		end
	end

	// One-cycle start pulse towards the array
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			erase_start_out <= 1'b0;
		end else begin
			erase_start_out <= go_page | go_block;
		end
	end

	// Erase request to the array: page or sector base, array fills with FFh
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			erase_req_out <= '0;
		end else if (go_page) begin
			erase_req_out.block <= 1'b0;
			erase_req_out.base <= {frame_addr[`SFE_ADDR_MSB:`SFE_PAGE_LSB],
				8'h00};
		end else if (go_block) begin
			erase_req_out.block <= 1'b1;
			erase_req_out.base <= {frame_addr[`SFE_ADDR_MSB:`SFE_SECTOR_LSB],
				16'h0000};
		end
	end

	// Busy lags its cause by one cycle, as every status output does
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			busy_flag_out <= 1'b0;
		end else begin
			busy_flag_out <= cycle_running;
		end
	end

	// Latch view for status reads
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			write_unlock_latch_out <= 1'b0;
		end else begin
			write_unlock_latch_out <= unlock_latch;
		end
	end

	// Standby needs deselect and no cycle running
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			standby_out <= 1'b1;
		end else begin
			standby_out <= cs_n_in & ~cycle_running &
				(state == sfe_pkg::ST_STANDBY);
		end
	end

	// Deep sleep shows only once the entry delay is over
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			deep_sleep_out <= 1'b0;
		end else begin
			deep_sleep_out <= (state == sfe_pkg::ST_SLEEP);
		end
	end

	// Lockout view; its release lags the counter by one cycle
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			lockout_out <= 1'b1;
		end else begin
			lockout_out <= locked;
		end
	end

endmodule : sfe_erase_power_seq

// Rising-edge finder for one pin sampled on the core clock
module sfe_rise_det #(
	parameter logic IDLE = 1'b0
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic pin_in,
	output logic rise_out
);

	// Reset to the idle level so release of reset gives no false edge
	logic pin_q;

	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			pin_q <= IDLE;
		end else begin
			pin_q <= pin_in;
		end
	end

	assign rise_out = pin_in & ~pin_q;

endmodule : sfe_rise_det

// ### testbench/sfe_seq_properties.sv
`timescale 1ns/1ps
module sfe_seq_properties (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdi_in,
	input wire logic wp_n_in,
	input wire logic ext_cycle_busy_in,
	input wire logic busy_flag_out,
	input wire logic write_unlock_latch_out,
	input wire logic standby_out,
	input wire logic deep_sleep_out,
	input wire logic lockout_out,
	input wire logic erase_start_out,
	input wire sfe_pkg::sfe_erase_req_t erase_req_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	start_state_a: assert property (erase_start_out |=> busy_flag_out && !write_unlock_latch_out)
		else $error("start without busy");
	start_latch_a: assert property (erase_start_out |-> $past(write_unlock_latch_out))
		else $error("start without latch");
	start_desel_a: assert property (erase_start_out |-> $past(cs_n_in) && !$past(cs_n_in, 3))
		else $error("start not at deselect");
	req_align_a: assert property (erase_start_out |-> (erase_req_out.block ?
		erase_req_out.base[15:0] == 16'h0000 : erase_req_out.base[7:0] == 8'h00))
		else $error("base misaligned");
	prot_sector_a: assert property (erase_start_out && !wp_n_in |-> erase_req_out.base[19:16] != 4'h0)
		else $error("protected erase");
	start_idle_a: assert property (erase_start_out |-> !$past(busy_flag_out) && !deep_sleep_out)
		else $error("start while busy");
	lock_guard_a: assert property ($rose(write_unlock_latch_out) |-> !$past(lockout_out) && !deep_sleep_out)
		else $error("unlock in lockout");
	reset_state_a: assert property ($rose(nrst_in) |-> !busy_flag_out && !write_unlock_latch_out
		&& !deep_sleep_out && lockout_out)
		else $error("bad power-up state");
	busy_len_a: assert property (erase_start_out |=> busy_flag_out [*8] ##[1:40] !busy_flag_out)
		else $error("busy length");
	standby_excl_a: assert property (busy_flag_out || deep_sleep_out |-> !standby_out)
		else $error("standby while active");
endmodule : sfe_seq_properties

bind sfe_erase_power_seq sfe_seq_properties chk (.*);

// ### testbench/sfe_host_model.sv
`timescale 1ns/1ps
module sfe_host_model (
	input wire logic clk_in,
	output logic cs_n_out,
	output logic sclk_out,
	output logic sdi_out
);
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end
	// One select per frame, MSB first, clock idles low
	task automatic frame(input logic [39:0] w, input int n);
		@(posedge clk_in);
		#1 cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			#1 sdi_out = w[39 - i];
			sclk_out = 1'b0;
			@(posedge clk_in);
			#1 sclk_out = 1'b1;
		end
		@(posedge clk_in);
		#1 sclk_out = 1'b0;
		@(posedge clk_in);
		#1 cs_n_out = 1'b1;
		// Released line must not keep its last bit
		sdi_out = ~sdi_out;
		repeat (2) @(posedge clk_in);
		// Hand back off the edge so callers never sample a launching edge
		#1;
	endtask : frame
endmodule : sfe_host_model

// ### testbench/serial_flash_erase_power_sequencer_bench.sv
`timescale 1ns/1ps
module serial_flash_erase_power_sequencer_bench;
	logic clk, nrst, cs_n, sclk, sdi, wp_n, ext;
	logic busy, wul, stby, deep, lock, start;
	sfe_pkg::sfe_erase_req_t req, got;
	int n_fail = 0, checked = 0, n_start = 0;
	sfe_host_model host (.clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));
	sfe_erase_power_seq #(.PAGE_ERASE_CYC(32'h0000_0014), .BLOCK_CLEAR_CYC(32'h0000_001E),
		.WRITE_LOCKOUT_CYC(32'h0000_0040)) uut (.core_clk_in(clk), .nrst_in(nrst),
		.cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(sdi), .wp_n_in(wp_n),
		.ext_cycle_busy_in(ext), .busy_flag_out(busy), .write_unlock_latch_out(wul),
		.standby_out(stby), .deep_sleep_out(deep), .lockout_out(lock),
		.erase_start_out(start), .erase_req_out(req));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (start === 1'b1) begin
		n_start++;
		got = req;
	end
	task automatic summarize();
		$display("checks %0d, failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : summarize
	task automatic chk(input logic [20:0] g, input logic [20:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wait_lo(ref logic s, input int lim);
		int i;
		for (i = 0; i < lim && s !== 1'b0; i++) cyc(1);
		if (s !== 1'b0) begin
			n_fail++;
			$display("wrong value at %0t: wait ran out", $time);
			summarize();
		end
	endtask : wait_lo
	// Optional unlock, then one erase frame of nb bits
	task automatic erase(input logic [7:0] op, input logic [23:0] a, input int nb,
		input logic ul, input logic go, input logic [20:0] e);
		int s;
		s = n_start;
		if (ul) host.frame({8'h01, 32'h0000_0000}, 8);
		host.frame({op, a, 8'h00}, nb);
		cyc(3);
		chk(21'(n_start - s), 21'(go));
		if (go) begin
			chk(got, e);
			chk({busy, wul}, 2'h2);
			wait_lo(busy, 60);
		end
	endtask : erase
	task automatic sleep_wake();
		host.frame({8'h04, 32'h0000_0000}, 8);
		cyc(68);
		chk(deep, 1'h0);
		cyc(12);
		chk({deep, stby}, 2'h2);
		erase(8'h02, 24'h05_0000, 32, 1'b1, 1'b0, 21'h00_0000);
		chk({deep, wul}, 2'h2);
		host.frame({8'h05, 32'h0000_0000}, 9);
		cyc(4);
		chk(deep, 1'h1);
		host.frame({8'h05, 32'h0000_0000}, 8);
		chk(deep, 1'h0);
		cyc(60);
		chk(stby, 1'h0);
		cyc(20);
		chk(stby, 1'h1);
	endtask : sleep_wake
	initial begin
		nrst = 1'b0;
		wp_n = 1'b1;
		ext = 1'b0;
		cyc(8);
		nrst = 1'b1;
		cyc(1);
		chk({busy, wul, deep, lock}, 4'h1);
		host.frame({8'h01, 32'h0000_0000}, 8);
		cyc(2);
		chk({wul, lock}, 2'h1);
		wait_lo(lock, 100);
		erase(8'h02, 24'h00_0100, 32, 1'b0, 1'b0, 21'h00_0000);
		erase(8'h02, 24'hF1_23C7, 32, 1'b1, 1'b1, 21'h01_2300);
		erase(8'h03, 24'hA5_6789, 32, 1'b1, 1'b1, 21'h15_0000);
		erase(8'h02, 24'h03_0000, 31, 1'b1, 1'b0, 21'h00_0000);
		erase(8'h03, 24'h03_0000, 33, 1'b1, 1'b0, 21'h00_0000);
		wp_n = 1'b0;
		erase(8'h02, 24'h00_1234, 32, 1'b1, 1'b0, 21'h00_0000);
		erase(8'h03, 24'h00_FFFF, 32, 1'b1, 1'b0, 21'h00_0000);
		erase(8'h02, 24'h01_0000, 32, 1'b1, 1'b1, 21'h01_0000);
		wp_n = 1'b1;
		host.frame({8'h01, 32'h0000_0000}, 8);
		ext = 1'b1;
		erase(8'h02, 24'h02_0000, 32, 1'b1, 1'b0, 21'h00_0000);
		chk({wul, busy, stby}, 3'h6);
		host.frame({8'h04, 32'h0000_0000}, 8);
		ext = 1'b0;
		cyc(80);
		chk(deep, 1'h0);
		erase(8'h02, 24'h02_0000, 32, 1'b0, 1'b1, 21'h02_0000);
		sleep_wake();
		host.frame({8'h04, 32'h0000_0000}, 8);
		cyc(80);
		nrst = 1'b0;
		host.frame({8'h01, 32'h0000_0000}, 8);
		nrst = 1'b1;
		cyc(1);
		chk({deep, wul, busy, stby, lock}, 5'h03);
		summarize();
	end
endmodule : serial_flash_erase_power_sequencer_bench
